// File: logic/tbp_prescaler.sv
`timescale 1ns/1ps
module tbp_prescaler (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic ext_sel,
  input wire logic [2:0] rate,
  input wire logic ext_in,
  // Count strobe
  output logic tick
);

  // ----------------------------------------
  // Divider and external edge
  // ----------------------------------------
  logic [7:0] div_reg;
  logic ext_prev_reg;
  logic [7:0] rate_mask;

  // Divide by 2^(8-rate): fcpu/256 at 000 down to fcpu/2 at 111
  assign rate_mask = 8'hff >> rate;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_reg <= 8'h00;
    end else if (ce) begin
      div_reg <= run ? div_reg + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_prev_reg <= 1'b0;
    end else if (ce) begin
      ext_prev_reg <= ext_in;
    end
  end

  // External source counts falling edges; rate is ignored then
  always_comb begin
    if (!run) begin
      tick = 1'b0;
    end else if (ext_sel) begin
      tick = ext_prev_reg & ~ext_in;
    end else begin
      tick = (div_reg & rate_mask) == rate_mask;
    end
  end

endmodule

// File: logic/tbp_timer_out.sv
`timescale 1ns/1ps
module tbp_timer_out (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External count source
  input wire logic ext_clk_in,
  // Shared output pin
  output logic pin_out,
  output logic pin_oe,
  output logic gpio_disable,
  // Interrupt request
  output logic irq_req,
  output logic [7:0] irq_vector
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] mode_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] reload_reg;
  logic flag_reg;
  logic flag_next;
  logic ien_reg;
  logic buzz_reg;
  logic pwm_reg;
  logic pwm_next;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic pin_out_reg;
  logic pin_oe_reg;
  logic irq_reg;

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  logic pwm_en;
  logic buz_en;
  logic aload;
  logic timer_en;
  logic tick;
  logic [7:0] mask;
  logic wrap;
  logic sw_ovf;
  logic ovf;
  logic setup;
  logic access;
  logic wr;
  logic mapped;

  assign pwm_en = mode_reg[tbp_pkg::MODE_PWM_EN];
  assign buz_en = mode_reg[tbp_pkg::MODE_BUZ_EN];
  assign aload = mode_reg[tbp_pkg::MODE_ALOAD];
  assign timer_en = mode_reg[tbp_pkg::MODE_TIMER_EN];

  assign setup = psel & ~penable;
  assign access = psel & penable & pready_reg;
  assign wr = access & pwrite & ~pslverr_reg;
  assign mapped = (paddr == tbp_pkg::ADDR_MODE) ||
                  (paddr == tbp_pkg::ADDR_COUNT) ||
                  (paddr == tbp_pkg::ADDR_RELOAD) ||
                  (paddr == tbp_pkg::ADDR_STATUS);

  // ----------------------------------------
  // Count strobe
  // ----------------------------------------
  tbp_prescaler u_prescaler (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .run(timer_en),
    .ext_sel(mode_reg[tbp_pkg::MODE_CKS]),
    .rate(mode_reg[tbp_pkg::MODE_RATE_HI:tbp_pkg::MODE_RATE_LO]),
    .ext_in(ext_clk_in),
    .tick(tick)
  );

  // ----------------------------------------
  // Modulus and overflow
  // ----------------------------------------
  // In PWM mode the buzzer and reload bits pick the modulus
  always_comb begin
    if (!pwm_en) begin
      mask = tbp_pkg::MASK_256;
    end else begin
      unique case ({aload, buz_en})
        2'b00: mask = tbp_pkg::MASK_256;
        2'b01: mask = tbp_pkg::MASK_64;
        2'b10: mask = tbp_pkg::MASK_32;
        2'b11: mask = tbp_pkg::MASK_16;
      endcase
    end
  end

  assign wrap = tick & ((count_reg & mask) == mask);
  assign sw_ovf = wr && (paddr == tbp_pkg::ADDR_COUNT) &&
                  (count_reg == tbp_pkg::COUNT_TOP) &&
                  (pwdata[7:0] == 8'h00);
  assign ovf = wrap | sw_ovf;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_comb begin
    if (wr && (paddr == tbp_pkg::ADDR_COUNT)) begin
      count_next = pwdata[7:0];
    end else if (wrap) begin
      if (!pwm_en && aload) begin
        count_next = reload_reg;
      end else begin
        count_next = 8'h00;
      end
    end else if (tick) begin
      count_next = (count_reg + 8'h01) & mask;
    end else begin
      count_next = count_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= tbp_pkg::COUNT_RESET;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  // ----------------------------------------
  // Mode and reload registers
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_reg <= tbp_pkg::MODE_RESET;
    end else if (ce && wr && paddr == tbp_pkg::ADDR_MODE) begin
      mode_reg <= pwdata[7:0];
    end
  end

  // Write-only: reads return zero, so software keeps a copy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reload_reg <= tbp_pkg::RELOAD_RESET;
    end else if (ce && wr && paddr == tbp_pkg::ADDR_RELOAD) begin
      reload_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Overflow flag and interrupt enable
  // ----------------------------------------
  // A hardware overflow beats a software clear in the same cycle
  always_comb begin
    flag_next = flag_reg;
    if (wr && paddr == tbp_pkg::ADDR_STATUS) begin
      flag_next = pwdata[tbp_pkg::STAT_FLAG];
    end
    if (ovf) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_reg <= 1'b0;
      ien_reg <= 1'b0;
    end else if (ce) begin
      flag_reg <= flag_next;
      if (wr && paddr == tbp_pkg::ADDR_STATUS) begin
        ien_reg <= pwdata[tbp_pkg::STAT_IEN];
      end
    end
  end

  // Request follows the cycle after enable meets a set flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= flag_reg & ien_reg;
    end
  end

  // ----------------------------------------
  // Buzzer
  // ----------------------------------------
  // Toggling per overflow halves the overflow rate
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buzz_reg <= 1'b0;
    end else if (ce) begin
      if (!timer_en) begin
        buzz_reg <= 1'b0;
      end else if (wrap && !pwm_en && buz_en) begin
        buzz_reg <= ~buzz_reg;
      end
    end
  end

  // ----------------------------------------
  // PWM compare
  // ----------------------------------------
  // Live compare means a mid-cycle reference raise can re-raise
  // the output; software avoids it by writing after overflow.
  // The count taken at this edge is compared, so the level carries
  // no extra lag against the wrap and a zero reference stays low
  always_comb begin
    if (wrap && (count_next == 8'h00)) begin
      pwm_next = (reload_reg & mask) != 8'h00;
    end else begin
      pwm_next = (count_next & mask) < (reload_reg & mask);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_reg <= 1'b0;
    end else if (ce) begin
      pwm_reg <= timer_en & pwm_en & pwm_next;
    end
  end

  // ----------------------------------------
  // Shared pin
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else if (ce) begin
      pin_out_reg <= pwm_en ? pwm_reg : (buz_en & buzz_reg);
      pin_oe_reg <= pwm_en | buz_en;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait-free access: ready rises for the first access cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup) begin
        unique case (paddr)
          tbp_pkg::ADDR_MODE: prdata_reg <= {24'h000000, mode_reg};
          tbp_pkg::ADDR_COUNT: prdata_reg <= {24'h000000, count_reg};
          tbp_pkg::ADDR_STATUS:
            prdata_reg <= {30'h0, ien_reg, flag_reg};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign gpio_disable = pin_oe_reg;
  assign irq_req = irq_reg;
  assign irq_vector = tbp_pkg::INT_VECTOR;

endmodule

// File: shared/tbp_pkg.sv
// Function
// - Buzzer wave is half the overflow rate
// - Buzzer enable takes pin, blocks GPIO
// - Timer enable clear stops count, outputs
// - Prescale select sits in mode bits 6:4
// - PWM modulus 256/64/32/16 from two bits
// - PWM set high at counter wrap unless reference is zero
// - PWM high while count below reference
// - Duty equals reference over modulus
// - Count write changes duty at once
// - Reference write compares at once
// - PWM wraps keep setting overflow flag
// - Count write 0xff to zero is overflow
// - Enable with flag set vectors next cycle
// - Reload reference is write-only
// - PWM enable takes pin, blocks GPIO
// - PWM and interrupt requests coexist
// - Auto-reload copies reference on overflow
// - Buzzer/reload bits select modulus in PWM
package tbp_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_RELOAD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // ----------------------------------------
  // Mode control fields
  // ----------------------------------------
  localparam int MODE_PWM_EN = 0;
  localparam int MODE_BUZ_EN = 1;
  localparam int MODE_ALOAD = 2;
  localparam int MODE_CKS = 3;
  localparam int MODE_RATE_LO = 4;
  localparam int MODE_RATE_HI = 6;
  localparam int MODE_TIMER_EN = 7;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // ----------------------------------------
  // Status fields
  // ----------------------------------------
  localparam int STAT_FLAG = 0;
  localparam int STAT_IEN = 1;

  // ----------------------------------------
  // Counter constants
  // ----------------------------------------
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hff;
  localparam logic [7:0] MASK_256 = 8'hff;
  localparam logic [7:0] MASK_64 = 8'h3f;
  localparam logic [7:0] MASK_32 = 8'h1f;
  localparam logic [7:0] MASK_16 = 8'h0f;
  localparam logic [7:0] INT_VECTOR = 8'h08;

endpackage

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ext_clk_in = 1'b0;
  logic ce = 1'b1;
  logic ext_hold = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_out, pin_oe, gpio_disable, irq_req;
  logic [7:0] irq_vector;
  logic [15:0] rises;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int num_checks = 0;
  always #50 clock = ~clock;
  always @(posedge clock) if (!ext_hold) ext_clk_in <= 1'($urandom);
  tbp_timer_out u_dut (.clock(clock), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_in(ext_clk_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .gpio_disable(gpio_disable), .irq_req(irq_req),
    .irq_vector(irq_vector));
  tbp_load u_load (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .rises(rises));
  // ----
  // Tasks
  // ----
  task check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      end_sim;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  // Read results are judged apart from the driver, oldest note first
  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite)
      check("read", prdata, exp_q.size() ? exp_q.pop_front() : 'x);
  end
  // ----
  // Sequence
  // ----
  initial begin
    int h;
    int per;
    logic [7:0] m;
    logic [7:0] r;
    logic [15:0] e0;
    logic p;
    void'($urandom(32'h8871));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(tbp_pkg::ADDR_MODE, 32'h0);
    rd(tbp_pkg::ADDR_COUNT, 32'h0);
    wr(tbp_pkg::ADDR_RELOAD, 8'h5a);
    rd(tbp_pkg::ADDR_RELOAD, 32'h0);
    rd(8'h10, 32'h0);
    wr(tbp_pkg::ADDR_COUNT, 8'hff);
    wr(tbp_pkg::ADDR_COUNT, 8'h00);
    rd(tbp_pkg::ADDR_STATUS, 32'h1);
    wr(tbp_pkg::ADDR_STATUS, 8'h03);
    repeat (2) @(posedge clock);
    check("irq request", irq_req, 1'b1);
    rd(tbp_pkg::ADDR_STATUS, 32'h3);
    wr(tbp_pkg::ADDR_STATUS, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      m = 8'hff >> (i == 0 ? 0 : i + 1);
      // Reference floor of one keeps a pulse in every period
      r = (8'($urandom) & m) | 8'h01;
      per = (m + 1) * 2;
      wr(tbp_pkg::ADDR_RELOAD, r);
      wr(tbp_pkg::ADDR_COUNT, 8'h00);
      wr(tbp_pkg::ADDR_MODE, 8'hf1 | 8'(i << 1));
      wr(tbp_pkg::ADDR_STATUS, 8'h00);
      repeat (3 * per) @(posedge clock);
      h = 0;
      repeat (4 * per) begin
        @(posedge clock);
        h += (pin_out === 1'b1);
      end
      check("pwm high", h, 8 * r);
      check("pwm pin", {pin_oe, gpio_disable}, 2'b11);
      rd(tbp_pkg::ADDR_STATUS, 32'h1);
    end
    // Clock enable low must hold every flop, the pin included
    ce <= 1'b0;
    @(posedge clock);
    p = pin_out;
    h = 0;
    repeat (40) begin
      @(posedge clock);
      h += (pin_out !== p);
    end
    ce <= 1'b1;
    check("frozen pin", h, 0);
    $display("test pwm done");
    for (int i = 0; i < 2; i++) begin
      wr(tbp_pkg::ADDR_RELOAD, 8'hc0);
      wr(tbp_pkg::ADDR_COUNT, 8'h00);
      wr(tbp_pkg::ADDR_MODE, 8'hf2 | 8'(i << 2));
      repeat (1100) @(posedge clock);
      e0 = rises;
      repeat (4096) @(posedge clock);
      check("buzzer rises", rises - e0, i ? 16 : 4);
    end
    wr(tbp_pkg::ADDR_MODE, 8'h02);
    repeat (4) @(posedge clock);
    check("stopped pin", pin_out, 1'b0);
    $display("test buzzer done");
    wr(tbp_pkg::ADDR_COUNT, 8'h00);
    wr(tbp_pkg::ADDR_MODE, 8'h88);
    // Falling edges of the external source are the count strobe
    p = ext_clk_in;
    h = 0;
    repeat (100) begin
      @(posedge clock);
      h += (p && !ext_clk_in);
      p = ext_clk_in;
    end
    ext_hold <= 1'b1;
    @(posedge clock);
    h += (p && !ext_clk_in);
    rd(tbp_pkg::ADDR_COUNT, 32'(h));
    $display("test ext done");
    end_sim;
  end
endmodule
bind tbp_timer_out tbp_chk u_chk (.clock(clock), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
  .gpio_disable(gpio_disable),
  .irq_req(irq_req), .irq_vector(irq_vector));

// File: sim/tbp_load.sv
`timescale 1ns/1ps
module tbp_load (
  // Clock
  input wire logic clock,
  // Pin
  input wire logic pin_out,
  input wire logic pin_oe,
  // Observed rising edges
  output logic [15:0] rises
);
  logic level;
  logic level_q;
  // Undriven pin rests low on the load's pull-down
  assign level = pin_oe ? pin_out : 1'b0;
  initial rises = 16'h0;
  always @(posedge clock) begin
    level_q <= level;
    if (level && !level_q) rises <= rises + 16'h1;
  end
endmodule

// File: sim/tbp_timer_out_assertions.sv
`timescale 1ns/1ps
module tbp_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and interrupt
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic gpio_disable,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  apb_wait_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  map_err_a: assert property (pready && paddr > 8'h0c |-> pslverr
    && prdata == 32'h0) else $error("unmapped access not refused");
  reload_wo_a: assert property (
    pready && !pwrite && paddr == 8'h08 |-> prdata == 32'h0)
    else $error("reload reference readable");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  pin_gpio_a: assert property (gpio_disable == pin_oe)
    else $error("gpio not blocked with pin driven");
  int_vector_a: assert property (irq_vector == 8'h08)
    else $error("wrong vector");
  idle_pin_low_a: assert property (!pin_oe |-> !pin_out)
    else $error("pin level set while not driven");
  // Flag and enable written together must raise the request quickly
  irq_follow_a: assert property (
    pready && pwrite && paddr == 8'h0c && pwdata[1:0] == 2'b11
    |-> ##[1:3] irq_req) else $error("request not raised");
endmodule
